// [pkg/adcs_pkg.sv]
package adcs_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int UNITS = 3;
  localparam int CHANS = 32;
  localparam int RES_W = 10;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;

  // ****************************************
  // Unit layout: first channel, channel count, register bank base
  // ****************************************
  localparam int UNIT_FIRST [UNITS] = '{0, 12, 24};
  localparam int UNIT_NCH [UNITS] = '{12, 12, 8};
  localparam logic [11:0] BANK_BASE [UNITS] = '{12'h800, 12'h820, 12'h840};
  localparam logic [11:0] CSR_OFS = 12'h018;
  localparam logic [11:0] CR_OFS = 12'h019;
  localparam logic [11:0] IRQ_STAT_ADDR = 12'h860;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h862;

  // ****************************************
  // Control/status fields and reset values
  // ****************************************
  localparam int CSR_FLAG_BIT = 7;
  localparam int CSR_IE_BIT = 6;
  localparam int CSR_RUN_BIT = 5;
  localparam int CSR_SCAN_BIT = 4;
  localparam int CSR_CH_LSB = 0;
  localparam logic [7:0] CSR_RST [UNITS] = '{8'h00, 8'h00, 8'h08};
  localparam int CR_TRG_LSB = 0;
  localparam int CR_CONT_BIT = 2;
  localparam int CR_DMA_BIT = 3;
  localparam logic [7:0] CR_RST = 8'h0F;
  localparam logic [1:0] TRG_PIN = 2'h1;
  localparam logic [1:0] TRG_TIMER = 2'h2;
  localparam int RES_SHIFT = 6;

  // ****************************************
  // Conversion timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_TIME_NS = 13400;
  localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_CYC = 20;
  localparam int SAMPLE_CYC = CONV_CYC - RES_W * BIT_CYC;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONVERT = 3'b100
  } adcs_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } adcs_bus_t;

  typedef struct packed {
    logic sample;
    logic [RES_W-1:0] trial;
    logic [4:0] channel;
  } adcs_afe_t;

endpackage

// [rtl/adcs_top.sv]
`timescale 1ns/100ps

// Function
// - Convert inputs to 10-bit codes by successive approximation over 32 channels.
// - Three independent units: two with twelve channels, one with eight.
// - Groups of four consecutive inputs; groups 0-2, 3-5, 6-7 per unit.
// - Single mode converts one chosen channel once, then stops.
// - Scan mode runs continuously or as one single pass.
// - Scan covers 1 to 12 channels on units 0 and 1, 1 to 8 on unit 2.
// - Each result lands in the result register of its own channel.
// - Each unit raises its own conversion-end interrupt line.
// - A unit's conversion-end request may instead activate DMA.
// - Start by software, by trigger pin, or by the unit's timer event.
// - A falling edge on the selected trigger pin starts the unit.
// - Pin a starts units 0 and 1; pin b starts unit 2 only.
// - Unit 2 drives a timing monitor while converting channel 31 in scan.
// - Each channel conversion lasts at least 13.4 us.
// - Result: upper eight bits in upper byte, low two at bits 7:6.
// - Results read zero after reset and after standby.
// - End flag clears by writing zero to bit 7 or by DMA acknowledge; one has no effect.
module adcs_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic standby,
  // Register port
  input wire adcs_pkg::adcs_bus_t bus,
  output logic [adcs_pkg::DATA_W-1:0] rdata,
  // Start sources
  input wire logic ext_start_pin_a_n,
  input wire logic ext_start_pin_b_n,
  input wire logic timer_interval_event_a,
  input wire logic timer_interval_event_b,
  input wire logic timer_interval_event_c,
  // Analog front end, one per unit
  output adcs_pkg::adcs_afe_t [adcs_pkg::UNITS-1:0] afe,
  input wire logic [adcs_pkg::UNITS-1:0] comp_high,
  // Interrupts and DMA
  output logic conversion_end_irq_u0,
  output logic conversion_end_irq_u1,
  output logic conversion_end_irq_u2,
  output logic [adcs_pkg::UNITS-1:0] dma_req,
  input wire logic [adcs_pkg::UNITS-1:0] dma_ack,
  output logic irq,
  // Monitor
  output logic scan_timing_monitor_out
);

  localparam int U = adcs_pkg::UNITS;

  // ****************************************
  // Shared state
  // ****************************************
  logic [adcs_pkg::RES_W-1:0] result [adcs_pkg::CHANS];
  logic [U-1:0] done_v;
  logic [U-1:0] pass_end_v;
  logic [U-1:0] mon_v;
  logic [U-1:0] cpu_irq_v;
  logic [adcs_pkg::RES_W-1:0] code_v [U];
  logic [4:0] ch_v [U];
  logic [7:0] csr_v [U];
  logic [7:0] cr_v [U];
  logic [U-1:0] irq_stat;
  logic [U-1:0] irq_mask;
  logic [adcs_pkg::DATA_W-1:0] next_rdata;
  logic pa_s1, pa_s2, pa_d;
  logic pb_s1, pb_s2, pb_d;
  logic [U-1:0] pin_fall;
  logic [U-1:0] tmr_ev;

  function automatic logic [11:0] res_addr(input int c);
    int u;
    u = (c < adcs_pkg::UNIT_FIRST[1]) ? 0 : (c < adcs_pkg::UNIT_FIRST[2]) ? 1 : 2;
    res_addr = adcs_pkg::BANK_BASE[u] + 12'((c - adcs_pkg::UNIT_FIRST[u]) * 2);
  endfunction

  // ****************************************
  // Trigger inputs
  // ****************************************
  // Pins are active low; only the second stage feeds the edge detector
  always_ff @(posedge clk) begin
    if (rst) begin
      pa_s1 <= 1'b1;
      pa_s2 <= 1'b1;
      pa_d <= 1'b1;
      pb_s1 <= 1'b1;
      pb_s2 <= 1'b1;
      pb_d <= 1'b1;
    end else begin
      pa_s1 <= ext_start_pin_a_n;
      pa_s2 <= pa_s1;
      pa_d <= pa_s2;
      pb_s1 <= ext_start_pin_b_n;
      pb_s2 <= pb_s1;
      pb_d <= pb_s2;
    end
  end

  // Pin a is shared by units 0 and 1
  assign pin_fall = {pb_d & ~pb_s2, pa_d & ~pa_s2, pa_d & ~pa_s2};
  assign tmr_ev = {timer_interval_event_c, timer_interval_event_b, timer_interval_event_a};

  // ****************************************
  // Converter units
  // ****************************************
  for (genvar u = 0; u < U; u++) begin : g_unit
    localparam logic [4:0] FIRST = 5'(adcs_pkg::UNIT_FIRST[u]);
    localparam logic [3:0] NLAST = 4'(adcs_pkg::UNIT_NCH[u] - 1);
    localparam logic [11:0] CSR_ADDR = adcs_pkg::BANK_BASE[u] + adcs_pkg::CSR_OFS;
    localparam logic [11:0] CR_ADDR = adcs_pkg::BANK_BASE[u] + adcs_pkg::CR_OFS;

    adcs_pkg::adcs_state_t state;
    logic [7:0] csr;
    logic [7:0] cr;
    logic [8:0] cnt;
    logic [3:0] bitn;
    logic [adcs_pkg::RES_W-1:0] sar;
    logic [4:0] ch;
    logic [3:0] sel;
    logic [3:0] last_local;
    logic [4:0] ch_last;
    logic [4:0] ch_start;
    logic run, scan, cont, ext_ev, trig_ok, csr_wr, cr_wr;
    logic bit_end, conv_end, stop_after;
    logic [adcs_pkg::RES_W-1:0] code;

    assign sel = csr[adcs_pkg::CSR_CH_LSB +: 4];
    // Out-of-range selections fall back to the unit's last channel
    assign last_local = (sel > NLAST) ? NLAST : sel;
    assign ch_last = FIRST + {1'b0, last_local};
    assign run = csr[adcs_pkg::CSR_RUN_BIT];
    assign scan = csr[adcs_pkg::CSR_SCAN_BIT];
    assign cont = cr[adcs_pkg::CR_CONT_BIT];
    // Scan starts at the unit's first channel, single at the chosen one
    assign ch_start = scan ? FIRST : ch_last;
    assign csr_wr = bus.wr && (bus.addr == CSR_ADDR);
    assign cr_wr = bus.wr && (bus.addr == CR_ADDR);
    assign ext_ev = (cr[adcs_pkg::CR_TRG_LSB +: 2] == adcs_pkg::TRG_PIN && pin_fall[u]) ||
                    (cr[adcs_pkg::CR_TRG_LSB +: 2] == adcs_pkg::TRG_TIMER && tmr_ev[u]);
    assign trig_ok = ext_ev && !run;
    assign bit_end = (state == adcs_pkg::ST_CONVERT) &&
                     (cnt == 9'(adcs_pkg::BIT_CYC - 1));
    assign conv_end = bit_end && (bitn == 4'h0);
    // Comparator decides the bit under trial
    assign code = comp_high[u] ? sar : (sar & ~(10'h001 << bitn));
    assign stop_after = !scan || !cont;

    // Control/status: run bit, flag, enables and channel
    always_ff @(posedge clk) begin
      if (rst || standby) begin
        csr <= adcs_pkg::CSR_RST[u];
      end else begin
        if (csr_wr) begin
          csr[6:0] <= bus.wdata[6:0];
        end
        if (csr_wr && !bus.wdata[adcs_pkg::CSR_FLAG_BIT]) begin
          csr[adcs_pkg::CSR_FLAG_BIT] <= 1'b0;
        end
        if (dma_ack[u]) begin
          csr[adcs_pkg::CSR_FLAG_BIT] <= 1'b0;
        end
        if (trig_ok) begin
          csr[adcs_pkg::CSR_RUN_BIT] <= 1'b1;
        end
        if (conv_end && (!scan || ch == ch_last) && stop_after) begin
          csr[adcs_pkg::CSR_RUN_BIT] <= 1'b0;
        end
        // A finishing pass wins over a simultaneous clear
        if (pass_end_v[u]) begin
          csr[adcs_pkg::CSR_FLAG_BIT] <= 1'b1;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (rst || standby) begin
        cr <= adcs_pkg::CR_RST;
      end else if (cr_wr) begin
        cr <= bus.wdata[7:0];
      end
    end

    // Sample, then ten bit trials; the sum is the full conversion time
    always_ff @(posedge clk) begin
      if (rst || standby) begin
        state <= adcs_pkg::ST_IDLE;
        cnt <= 9'h000;
        bitn <= 4'h9;
        sar <= 10'h200;
        ch <= 5'h00;
      end else begin
        case (state)
          adcs_pkg::ST_IDLE: begin
            cnt <= 9'h000;
            if (run) begin
              state <= adcs_pkg::ST_SAMPLE;
              ch <= ch_start;
            end
          end
          adcs_pkg::ST_SAMPLE: begin
            if (!run) begin
              state <= adcs_pkg::ST_IDLE;
            end else if (cnt == 9'(adcs_pkg::SAMPLE_CYC - 1)) begin
              state <= adcs_pkg::ST_CONVERT;
              cnt <= 9'h000;
              bitn <= 4'h9;
              sar <= 10'h200;
            end else begin
              cnt <= cnt + 9'h001;
            end
          end
          adcs_pkg::ST_CONVERT: begin
            if (!run) begin
              state <= adcs_pkg::ST_IDLE;
            end else if (!bit_end) begin
              cnt <= cnt + 9'h001;
            end else if (bitn != 4'h0) begin
              cnt <= 9'h000;
              bitn <= bitn - 4'h1;
              sar <= code | (10'h001 << (bitn - 4'h1));
            end else begin
              cnt <= 9'h000;
              state <= adcs_pkg::ST_SAMPLE;
              if (scan && ch != ch_last) begin
                ch <= ch + 5'h01;
              end else if (!stop_after) begin
                ch <= FIRST;
              end else begin
                state <= adcs_pkg::ST_IDLE;
              end
            end
          end
          default: begin
            state <= adcs_pkg::ST_IDLE;
          end
        endcase
      end
    end

    assign done_v[u] = conv_end && run;
    assign pass_end_v[u] = conv_end && run && (!scan || ch == ch_last);
    assign code_v[u] = code;
    assign ch_v[u] = ch;
    assign csr_v[u] = csr;
    assign cr_v[u] = cr;
    assign mon_v[u] = (state != adcs_pkg::ST_IDLE) && scan && (ch == 5'h1F);
    assign afe[u].sample = (state == adcs_pkg::ST_SAMPLE);
    assign afe[u].trial = sar;
    assign afe[u].channel = ch;
    // Enabled request goes either to the CPU or to DMA
    assign cpu_irq_v[u] = csr[adcs_pkg::CSR_FLAG_BIT] && csr[adcs_pkg::CSR_IE_BIT] &&
                          !cr[adcs_pkg::CR_DMA_BIT];
    assign dma_req[u] = csr[adcs_pkg::CSR_FLAG_BIT] && csr[adcs_pkg::CSR_IE_BIT] &&
                        cr[adcs_pkg::CR_DMA_BIT];
  end

  assign conversion_end_irq_u0 = cpu_irq_v[0];
  assign conversion_end_irq_u1 = cpu_irq_v[1];
  assign conversion_end_irq_u2 = cpu_irq_v[2];

  // ****************************************
  // Result store
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst || standby) begin
      for (int c = 0; c < adcs_pkg::CHANS; c++) begin
        result[c] <= '0;
      end
    end else begin
      for (int u = 0; u < U; u++) begin
        if (done_v[u]) begin
          result[ch_v[u]] <= code_v[u];
        end
      end
    end
  end

  // Unit 2 owns the monitor pin
  always_ff @(posedge clk) begin
    if (rst) begin
      scan_timing_monitor_out <= 1'b0;
    end else begin
      scan_timing_monitor_out <= mon_v[2];
    end
  end

  // ****************************************
  // Summary interrupt
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat <= '0;
    end else begin
      // Set wins over a write-one clear in the same cycle
      irq_stat <= (irq_stat & ~((bus.wr && bus.addr == adcs_pkg::IRQ_STAT_ADDR) ?
                   bus.wdata[U-1:0] : '0)) | pass_end_v;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask <= '0;
    end else if (bus.wr && bus.addr == adcs_pkg::IRQ_MASK_ADDR) begin
      irq_mask <= bus.wdata[U-1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    next_rdata = '0;
    for (int c = 0; c < adcs_pkg::CHANS; c++) begin
      if (bus.addr == res_addr(c)) begin
        next_rdata = {result[c], 6'h00};
      end
    end
    for (int u = 0; u < U; u++) begin
      if (bus.addr == adcs_pkg::BANK_BASE[u] + adcs_pkg::CSR_OFS) begin
        next_rdata = {8'h00, csr_v[u]};
      end
      if (bus.addr == adcs_pkg::BANK_BASE[u] + adcs_pkg::CR_OFS) begin
        next_rdata = {8'h00, cr_v[u]};
      end
    end
    if (bus.addr == adcs_pkg::IRQ_STAT_ADDR) begin
      next_rdata = {13'h0000, irq_stat};
    end
    if (bus.addr == adcs_pkg::IRQ_MASK_ADDR) begin
      next_rdata = {13'h0000, irq_mask};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (bus.rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= '0;
    end
  end

endmodule

// [verif/adcs_assertions.sv]
`timescale 1ns/100ps
module adcs_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic standby,
  // Register port
  input wire adcs_pkg::adcs_bus_t bus,
  input wire logic [15:0] rdata,
  // Converter side
  input wire adcs_pkg::adcs_afe_t [2:0] afe,
  input wire logic conversion_end_irq_u0,
  input wire logic [2:0] dma_req,
  input wire logic [2:0] dma_ack,
  input wire logic irq,
  input wire logic scan_timing_monitor_out
);
  // ****
  // Sampling length of unit 0
  // ****
  int scnt;
  always_ff @(posedge clk) begin
    scnt <= (rst || !afe[0].sample) ? 0 : scnt + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  rd_idle_a: assert property (!$past(bus.rd) |-> rdata == 16'h0000)
    else $error("read data outside read slot");
  samp_len_a: assert property (
    $fell(afe[0].sample) && !$past(bus.wr) && !$past(standby)
    |-> scnt == adcs_pkg::SAMPLE_CYC) else $error("sampling phase length wrong");
  trial_msb_a: assert property (
    $fell(afe[0].sample) && !$past(bus.wr) && !$past(standby)
    |-> afe[0].trial == 10'h200) else $error("first trial code wrong");
  irq_or_dma_a: assert property (!(conversion_end_irq_u0 && dma_req[0]))
    else $error("interrupt and dma both raised");
  dma_clear_a: assert property (dma_req[0] && dma_ack[0] |=> !dma_req[0])
    else $error("dma request kept after ack");
  flag_hold_a: assert property (
    $fell(conversion_end_irq_u0) |-> $past(bus.wr) || $past(standby))
    else $error("end flag lost without write");
  irq_sticky_a: assert property ($fell(irq) |-> $past(bus.wr))
    else $error("interrupt dropped without write");
  mon_chan_a: assert property (
    scan_timing_monitor_out |-> $past(afe[2].channel) == 5'h1F)
    else $error("monitor high off channel 31");
  u1_range_a: assert property (
    afe[1].sample |-> afe[1].channel inside {[5'd12:5'd23]})
    else $error("unit 1 channel out of its groups");
  cover property ($rose(irq));
  cover property ($rose(scan_timing_monitor_out));
  cover property (dma_req[0] && dma_ack[0]);
endmodule
bind adcs_top adcs_assertions chk (.clk, .rst, .standby, .bus, .rdata, .afe,
  .conversion_end_irq_u0, .dma_req, .dma_ack, .irq, .scan_timing_monitor_out);

// [verif/adcs_trig_model.sv]
`timescale 1ns/100ps
module adcs_trig_model (
  // Clock
  input wire logic clk,
  // Trigger pins, idle high
  output logic pin_a_n,
  output logic pin_b_n,
  // Timer interval events
  output logic [2:0] tev
);
  initial begin
    pin_a_n = 1'b1;
    pin_b_n = 1'b1;
    tev = 3'h0;
  end
  // Held low long enough to cross the two-stage synchroniser
  task automatic pull_pin(input int p);
    if (p == 0) pin_a_n <= 1'b0;
    else pin_b_n <= 1'b0;
    repeat (4) @(posedge clk);
    pin_a_n <= 1'b1;
    pin_b_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic fire_event(input int e);
    tev[e] <= 1'b1;
    @(posedge clk);
    tev <= 3'h0;
    @(posedge clk);
  endtask
endmodule

// [verif/adcs_sequencer_three_unit_test.sv]
`timescale 1ns/100ps
module adcs_sequencer_three_unit_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic standby = 1'b0;
  adcs_pkg::adcs_bus_t bus = '0;
  adcs_pkg::adcs_afe_t [2:0] afe;
  logic [15:0] rdata;
  logic pin_a_n, pin_b_n, irq_u0, irq_u1, irq_u2, irq, mon;
  logic [2:0] tev, dma_req;
  logic [2:0] comp_high = '0;
  logic [2:0] dma_ack = '0;
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 10815;
  int ana [32];
  int c;
  always #25 clk = ~clk;
  // Analog side: each input compared with the trial code
  always @(posedge clk) begin
    for (int u = 0; u < 3; u++) comp_high[u] <= ana[afe[u].channel] >= int'(afe[u].trial);
  end
  adcs_top dut (.clk, .rst, .standby, .bus, .rdata, .ext_start_pin_a_n(pin_a_n),
    .ext_start_pin_b_n(pin_b_n), .timer_interval_event_a(tev[0]),
    .timer_interval_event_b(tev[1]), .timer_interval_event_c(tev[2]), .afe, .comp_high,
    .conversion_end_irq_u0(irq_u0), .conversion_end_irq_u1(irq_u1),
    .conversion_end_irq_u2(irq_u2), .dma_req, .dma_ack, .irq, .scan_timing_monitor_out(mon));
  adcs_trig_model trg (.clk, .pin_a_n, .pin_b_n, .tev);
  // ****
  // Helpers
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(posedge clk);
    chk(rdata, e);
  endtask
  function automatic logic [11:0] csr(input int u);
    return adcs_pkg::BANK_BASE[u] + adcs_pkg::CSR_OFS;
  endfunction
  function automatic logic [11:0] cr(input int u);
    return adcs_pkg::BANK_BASE[u] + adcs_pkg::CR_OFS;
  endfunction
  // Reference model of the result register contents
  task automatic chk_res(input int ch, input bit zero);
    int u;
    u = ch / 12;
    rd(adcs_pkg::BANK_BASE[u] + 12'(2 * (ch - adcs_pkg::UNIT_FIRST[u])),
      zero ? 16'h0000 : 16'(ana[ch] << 6));
  endtask
  function automatic logic sel(input int k);
    logic [5:0] v;
    v = {afe[2].sample, mon, dma_req[0], irq_u2, irq_u1, irq_u0};
    return v[k];
  endfunction
  task automatic wait_hi(input int k, input int lim);
    for (c = 0; c < lim && sel(k) !== 1'b1; c++) @(posedge clk);
    if (c == lim) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks: %0d  mismatches: %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  initial begin
    for (int i = 0; i < 32; i++) ana[i] = $random(seed) & 32'h3FF;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int u = 0; u < 3; u++) begin
      rd(csr(u), {8'h00, adcs_pkg::CSR_RST[u]});
      rd(cr(u), {8'h00, adcs_pkg::CR_RST});
    end
    rd(12'h8FE, 16'h0000);
    for (int i = 0; i < 32; i++) chk_res(i, 1'b1);
    wr(cr(0), 16'h0000);
    wr(csr(0), 16'h0062);
    wait_hi(0, 400);
    chk1(c >= adcs_pkg::CONV_CYC, 1'b1);
    chk1(c <= adcs_pkg::CONV_CYC + 2, 1'b1);
    chk_res(2, 1'b0);
    rd(csr(0), 16'h00C2);
    wr(csr(0), 16'h00C2);
    chk1(irq_u0, 1'b1);
    wr(adcs_pkg::IRQ_MASK_ADDR, 16'h0007);
    chk1(irq, 1'b1);
    wr(adcs_pkg::IRQ_MASK_ADDR, 16'h0000);
    chk1(irq, 1'b0);
    wr(adcs_pkg::IRQ_STAT_ADDR, 16'h0001);
    wr(adcs_pkg::IRQ_MASK_ADDR, 16'h0007);
    chk1(irq, 1'b0);
    wr(csr(0), 16'h0042);
    chk1(irq_u0, 1'b0);
    // Pin a starts unit 1 one-pass scan, never unit 2
    wr(cr(1), 16'h0001);
    wr(csr(1), 16'h0052);
    wr(cr(2), 16'h0005);
    wr(csr(2), 16'h0057);
    trg.pull_pin(0);
    rd(csr(2), 16'h0057);
    wait_hi(1, 900);
    for (int i = 12; i < 15; i++) chk_res(i, 1'b0);
    chk_res(15, 1'b1);
    rd(csr(1), 16'h00D2);
    // Pin b starts unit 2 continuous scan through channel 31
    trg.pull_pin(1);
    wait_hi(4, 2500);
    wait_hi(2, 400);
    wait_hi(5, 20);
    for (int i = 24; i < 32; i++) chk_res(i, 1'b0);
    wr(csr(2), 16'h0057);
    rd(csr(2), 16'h0057);
    // Timer start routed to DMA; a second event while busy is dropped
    wr(cr(0), 16'h000A);
    wr(csr(0), 16'h0040);
    trg.fire_event(0);
    trg.fire_event(0);
    wait_hi(3, 400);
    chk1(irq_u0, 1'b0);
    dma_ack[0] <= 1'b1;
    @(posedge clk);
    dma_ack[0] <= 1'b0;
    repeat (3) @(posedge clk);
    chk1(dma_req[0], 1'b0);
    chk1(afe[0].sample, 1'b0);
    chk_res(0, 1'b0);
    for (int u = 1; u < 3; u++) begin
      wr(cr(u), 16'h0002);
      wr(csr(u), 16'h0040);
      trg.fire_event(u);
      wait_hi(u, 400);
      chk_res(12 * u, 1'b0);
    end
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    @(posedge clk);
    chk_res(24, 1'b1);
    rd(csr(2), {8'h00, adcs_pkg::CSR_RST[2]});
    tally_and_finish();
  end
endmodule
